//--- pps_cfg.svh
// pps_cfg.svh: offsets, field positions and timing constants of the
// power-state controller. Assumes a 100 MHz mclk.
`ifndef PPS_CFG_SVH
`define PPS_CFG_SVH

// configuration-space byte offsets
`define PPS_OFF_BAR_CSR   8'h10
`define PPS_OFF_BAR_MEM   8'h14
`define PPS_OFF_BAR_IO    8'h18
`define PPS_OFF_PMC       8'hDE
`define PPS_OFF_PM_CONTROL_STATUS     8'hE0
`define PPS_OFF_DRIVER_PM_REGISTER      8'hE2
`define PPS_OFF_STAT      8'hE4

// pm_control_status fields
`define PPS_PM_CONTROL_STATUS_ST_LO   0
`define PPS_PM_CONTROL_STATUS_ST_HI   1
`define PPS_PM_CONTROL_STATUS_PME_EN  8
`define PPS_PM_CONTROL_STATUS_PME_ST  15
`define PPS_ST_D0         2'h0
`define PPS_ST_D1         2'h1
`define PPS_ST_D2         2'h2
`define PPS_ST_D3         2'h3

// driver_pm_register field
`define PPS_DRIVER_PM_REGISTER_DEEP_EN  0

// power_mgmt_capability: base value arbitrary, aux bit set by strap
`define PPS_PMC_BASE      16'h0002
`define PPS_PMC_AUX_BIT   15

// timing
`define PPS_CLK_NS        10
`define PPS_IDLE_NS       500
`define PPS_IDLE_CYC      (`PPS_IDLE_NS / `PPS_CLK_NS)
`define PPS_IDLE_W        6
`define PPS_POR_WIN_CYC   5'h10
`define PPS_POR_W         5

// synchroniser reset image: alt,iso,brst,aux,link,wake,clkrun
`define PPS_SYNC_RST      7'h71

`endif

//--- pps_ctrl.sv
// pps_ctrl: power-state, wake, strap and isolation control of a bus
// network controller, reached through configuration-space accesses.
// Assumes pins are asynchronous; cfg and local requests are on mclk.
`include "pps_cfg.svh"

module pps_ctrl (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // pins, asynchronous
   input  wire logic        alternate_por_n,
   input  wire logic        isolate_n,
   input  wire logic        bus_rst_n,
   input  wire logic        flash_addr_line_one,
   input  wire logic        link_valid,
   input  wire logic        wake_pkt,
   input  wire logic        clkrun_n_in,
   // configuration access
   input  wire logic        cfg_rd,
   input  wire logic        cfg_wr,
   input  wire logic [7:0]  cfg_addr,
   input  wire logic [15:0] cfg_wdata,
   output logic      [15:0] cfg_rdata,
   output logic             cfg_ack,
   // local requests
   input  wire logic        bus_idle,
   input  wire logic        master_req,
   input  wire logic        intr_req,
   // bus side
   output logic             master_gnt,
   output logic             intr_out,
   output logic             bus_oe_n,
   output logic             clkrun_n_out,
   output logic             clkrun_oe_n,
   output logic             pme_n_out,
   output logic             pme_oe_n,
   // link side
   output logic             link_keep,
   output logic             link_deep_pd,
   output logic             standby,
   output logic             dev_init
);
   logic [6:0]            sync_q;
   logic                  alt_s, iso_s, brst_s, aux_s, link_s;
   logic                  wake_s, clkrun_s;
   logic                  iso_d_r, brst_d_r, link_d_r;
   logic                  init_r, full_init_r;
   logic                  por_win_r;
   logic [`PPS_POR_W-1:0] por_cnt_r;
   logic                  aux_r;
   pps_pkg::pps_state_e   state_r, state_nxt;
   logic [1:0]            st_field_r;
   logic                  pme_en_r, pme_st_r, deep_en_r;
   logic                  wake_ev, acc_ok, wr_pm_control_status;
   logic [`PPS_IDLE_W-1:0] idle_cnt_r;
   logic                  standby_r;
   logic                  low_pwr, link_down_deep, no_wake;

   pps_sync #(.W(7), .RST_VAL(`PPS_SYNC_RST)) u_sync (
      .mclk  (mclk),
      .rst_n (rst_n),
      .d     ({alternate_por_n, isolate_n, bus_rst_n,
               flash_addr_line_one, link_valid, wake_pkt, clkrun_n_in}),
      .q     (sync_q)
   );
   assign {alt_s, iso_s, brst_s, aux_s, link_s, wake_s, clkrun_s} = sync_q;

   function automatic logic is_bar(input logic [7:0] a);
      is_bar = (a == `PPS_OFF_BAR_CSR) || (a == `PPS_OFF_BAR_MEM) ||
               (a == `PPS_OFF_BAR_IO);
   endfunction : is_bar

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         iso_d_r  <= 1'b1;
         brst_d_r <= 1'b1;
         link_d_r <= 1'b0;
      end else begin
         iso_d_r  <= iso_s;
         brst_d_r <= brst_s;
         link_d_r <= link_s;
      end
   end

   // internal initialisation; bus reset only counts when not isolated
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         init_r      <= 1'b1;
         full_init_r <= 1'b1;
      end else begin
         full_init_r <= !alt_s;
         init_r <= !alt_s
                 || (iso_s && iso_d_r && !brst_s
                     && state_r != pps_pkg::PPS_D3)
                 || (iso_s && iso_d_r && brst_s && !brst_d_r
                     && state_r == pps_pkg::PPS_D3)
                 || (iso_s && !iso_d_r);
      end
   end

   // strap window: open at power-on and on alternate reset
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         por_cnt_r <= `PPS_POR_WIN_CYC;
         por_win_r <= 1'b1;
      end else if (full_init_r) begin
         por_cnt_r <= `PPS_POR_WIN_CYC;
         por_win_r <= 1'b1;
      end else if (por_cnt_r != '0) begin
         por_cnt_r <= por_cnt_r - 1'b1;
      end else begin
         por_win_r <= 1'b0;
      end
   end

   // strap is caught by clock, never by the async reset itself
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         aux_r <= 1'b0;
      end else if (por_win_r) begin
         aux_r <= aux_s;
      end
   end

   // accesses need the bus present and no reset pending
   assign acc_ok   = iso_s && !init_r;
   assign wr_pm_control_status = acc_ok && cfg_wr && cfg_addr == `PPS_OFF_PM_CONTROL_STATUS;

   // power state from written field plus base register history
   always_comb begin
      state_nxt = state_r;
      if (wr_pm_control_status) begin
         case (cfg_wdata[`PPS_PM_CONTROL_STATUS_ST_HI:`PPS_PM_CONTROL_STATUS_ST_LO])
            `PPS_ST_D1: state_nxt = pps_pkg::PPS_D1;
            `PPS_ST_D2: state_nxt = pps_pkg::PPS_D2;
            `PPS_ST_D3: state_nxt = pps_pkg::PPS_D3;
            default:    state_nxt = (state_r == pps_pkg::PPS_D0U) ?
                                    pps_pkg::PPS_D0U : pps_pkg::PPS_D0A;
         endcase
      end else if (acc_ok && cfg_wr && is_bar(cfg_addr)
                   && state_r == pps_pkg::PPS_D0U) begin
         state_nxt = pps_pkg::PPS_D0A;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= pps_pkg::PPS_D0U;
      end else if (init_r) begin
         state_r <= pps_pkg::PPS_D0U;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_field_r <= `PPS_ST_D0;
      end else if (init_r) begin
         st_field_r <= `PPS_ST_D0;
      end else if (wr_pm_control_status) begin
         st_field_r <= cfg_wdata[`PPS_PM_CONTROL_STATUS_ST_HI:`PPS_PM_CONTROL_STATUS_ST_LO];
      end
   end

   assign low_pwr = state_r == pps_pkg::PPS_D2
                 || state_r == pps_pkg::PPS_D3;
   assign no_wake = state_r == pps_pkg::PPS_D3 && !pme_en_r;

   // link edges count in every state but D3 with event enable clear; packets only in sleep states
   // link edges masked in the strap window: the sync leaves its reset image
   assign wake_ev = !no_wake
                 && ((link_s != link_d_r && !por_win_r)
                     || (wake_s && link_s
                         && state_r != pps_pkg::PPS_D0U
                         && state_r != pps_pkg::PPS_D0A));

   // event enable survives ordinary init while it is set
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pme_en_r <= 1'b0;
      end else if (full_init_r || (init_r && !pme_en_r)) begin
         pme_en_r <= 1'b0;
      end else if (wr_pm_control_status) begin
         pme_en_r <= cfg_wdata[`PPS_PM_CONTROL_STATUS_PME_EN];
      end
   end

   // sticky status: set wins over write-one-to-clear
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pme_st_r <= 1'b0;
      end else if (full_init_r || (init_r && !pme_en_r)) begin
         pme_st_r <= 1'b0;
      end else if (wake_ev) begin
         pme_st_r <= 1'b1;
      end else if (wr_pm_control_status && cfg_wdata[`PPS_PM_CONTROL_STATUS_PME_ST]) begin
         pme_st_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         deep_en_r <= 1'b0;
      end else if (full_init_r || (init_r && !pme_en_r)) begin
         deep_en_r <= 1'b0;
      end else if (acc_ok && cfg_wr && cfg_addr == `PPS_OFF_DRIVER_PM_REGISTER) begin
         deep_en_r <= cfg_wdata[`PPS_DRIVER_PM_REGISTER_DEEP_EN];
      end
   end

   // register reads; all registers stay reachable in every state
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_rdata <= '0;
         cfg_ack   <= 1'b0;
      end else begin
         cfg_ack   <= acc_ok && (cfg_rd || cfg_wr);
         cfg_rdata <= '0;
         if (acc_ok && cfg_rd) begin
            case (cfg_addr)
               `PPS_OFF_PMC: begin
                  cfg_rdata <= `PPS_PMC_BASE;
                  cfg_rdata[`PPS_PMC_AUX_BIT] <= aux_r;
               end
               `PPS_OFF_PM_CONTROL_STATUS: begin
                  cfg_rdata[`PPS_PM_CONTROL_STATUS_ST_HI:`PPS_PM_CONTROL_STATUS_ST_LO]
                     <= st_field_r;
                  cfg_rdata[`PPS_PM_CONTROL_STATUS_PME_EN] <= pme_en_r;
                  cfg_rdata[`PPS_PM_CONTROL_STATUS_PME_ST] <= pme_st_r;
               end
               `PPS_OFF_DRIVER_PM_REGISTER:
                  cfg_rdata[`PPS_DRIVER_PM_REGISTER_DEEP_EN] <= deep_en_r;
               `PPS_OFF_STAT:
                  cfg_rdata[2:0] <= state_r;
               default:
                  cfg_rdata <= '0;
            endcase
         end
      end
   end

   // standby: hidden from software, timed on local idleness
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         idle_cnt_r <= '0;
         standby_r  <= 1'b0;
      end else if (state_r != pps_pkg::PPS_D0A || !bus_idle) begin
         idle_cnt_r <= '0;
         standby_r  <= 1'b0;
      end else if (idle_cnt_r
                   != `PPS_IDLE_W'(`PPS_IDLE_CYC - 1)) begin
         idle_cnt_r <= idle_cnt_r + 1'b1;
      end else begin
         standby_r  <= 1'b1;
      end
   end
   assign standby = standby_r;

   // consecutive idle cycles counted for the checks, saturating
   logic [`PPS_IDLE_W-1:0] chk_idle_r;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         chk_idle_r <= '0;
      end else if (state_r != pps_pkg::PPS_D0A || !bus_idle) begin
         chk_idle_r <= '0;
      end else if (chk_idle_r != '1) begin
         chk_idle_r <= chk_idle_r + 1'b1;
      end
   end

   // clock claimed only while busy; idle lets host stop it
   assign clkrun_n_out = 1'b0;
   assign clkrun_oe_n  = !(iso_s && state_r == pps_pkg::PPS_D0A
                           && !standby_r && clkrun_s);

   // mastering and interrupts only in active full power
   assign master_gnt = master_req && iso_s
                    && state_r == pps_pkg::PPS_D0A;
   assign intr_out   = intr_req && iso_s && !init_r
                    && state_r == pps_pkg::PPS_D0A;
   assign bus_oe_n   = !iso_s;

   // event output is open drain and ignores isolation
   assign pme_n_out = 1'b0;
   assign pme_oe_n  = !(pme_st_r && pme_en_r);

   // link: deep mode drops idles and pulses entirely
   assign link_down_deep = low_pwr && !link_s && deep_en_r;
   assign link_deep_pd   = link_down_deep || no_wake;
   assign link_keep      = !link_deep_pd;
   assign dev_init       = init_r;

   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_uninit_hold: assert property (
      init_r |=> state_r == pps_pkg::PPS_D0U)
      else $error("state not uninitialised after init");

   a_bar_activate: assert property (
      state_r == pps_pkg::PPS_D0U && acc_ok && cfg_wr
      && is_bar(cfg_addr) && !wr_pm_control_status |=> state_r == pps_pkg::PPS_D0A)
      else $error("base register write did not activate");

   a_no_master: assert property (
      state_r != pps_pkg::PPS_D0A |-> !master_gnt && !intr_out)
      else $error("bus activity outside active state");

   a_standby_time: assert property (
      standby_r |-> chk_idle_r >= `PPS_IDLE_W'(`PPS_IDLE_CYC))
      else $error("standby entered too early");

   a_pme_drive: assert property (
      wake_ev && pme_en_r && !init_r && !wr_pm_control_status |=> !pme_oe_n)
      else $error("wake did not drive event output");

   a_pme_gate: assert property (
      !pme_en_r |-> pme_oe_n)
      else $error("event driven while disabled");

   a_deep_mode: assert property (
      link_deep_pd |-> !link_keep
      && (state_r == pps_pkg::PPS_D2 || state_r == pps_pkg::PPS_D3))
      else $error("deep mode outside low power");

   a_link_wake: assert property (
      link_s != link_d_r && !no_wake && !init_r && !por_win_r
      && !full_init_r |=> pme_st_r)
      else $error("link change not recorded");

   a_iso_release: assert property (
      $rose(iso_s) |=> init_r ##1 state_r == pps_pkg::PPS_D0U)
      else $error("no init after isolate release");

   a_iso_tristate: assert property (
      !iso_s |-> bus_oe_n && clkrun_oe_n ##1 !cfg_ack)
      else $error("bus outputs driven while isolated");

   a_strap_latch: assert property (
      por_win_r |=> aux_r == $past(aux_s))
      else $error("strap not sampled in window");
endmodule : pps_ctrl

//--- pps_host.sv
// pps_host.sv: behavioural bus host facing the power-state controller.
// Assumes the bench clock; every pin changes at the falling edge.
module pps_host (
   // clock
   input  wire logic        mclk,
   // configuration access
   output logic             cfg_rd,
   output logic             cfg_wr,
   output logic [7:0]       cfg_addr,
   output logic [15:0]      cfg_wdata,
   input  wire logic [15:0] cfg_rdata,
   input  wire logic        cfg_ack,
   // bus pins
   output logic             isolate_n,
   output logic             bus_rst_n,
   output logic             host_stop
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      cfg_rd    = 1'b0;
      cfg_wr    = 1'b0;
      cfg_addr  = 8'h00;
      cfg_wdata = 16'h0000;
      isolate_n = 1'b1;
      bus_rst_n = 1'b1;
      host_stop = 1'b0;
   end

   // one-cycle strobe; the answer is due one edge later
   task automatic access(input logic wr, input logic [7:0] a,
                         input logic [15:0] d, output logic ack,
                         output logic [15:0] rd);
      @(negedge mclk);
      cfg_wr    = wr;
      cfg_rd    = ~wr;
      cfg_addr  = a;
      cfg_wdata = d;
      @(negedge mclk);
      ack       = cfg_ack;
      rd        = cfg_rdata;
      cfg_wr    = 1'b0;
      cfg_rd    = 1'b0;
      // released lines carry no stale value
      cfg_addr  = ~a;
      cfg_wdata = ~d;
   endtask : access

   task automatic pins(input logic iso, input logic brst, input logic stop);
      @(negedge mclk);
      isolate_n = iso;
      bus_rst_n = brst;
      host_stop = stop;
   endtask : pins
endmodule : pps_host

//--- pps_pkg.sv
// pps_pkg: types of the power-state controller.
// Assumes pps_cfg.svh for all numeric constants.
package pps_pkg;
   typedef enum logic [2:0] {
      PPS_D0U, PPS_D0A, PPS_D1, PPS_D2, PPS_D3
   } pps_state_e;
endpackage : pps_pkg

//--- pps_sync.sv
// pps_sync: two-flop synchroniser for a vector of pin inputs.
// Assumes each bit is an independent level.
module pps_sync #(
   parameter int         W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and reset
   input  wire logic         mclk,
   input  wire logic         rst_n,
   // levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= RST_VAL;
         q      <= RST_VAL;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule : pps_sync

//--- test_pps_ctrl.sv
// test_pps_ctrl.sv: self-checking bench of the power-state controller.
// Assumes pps_host as bus partner; link and board pins are driven here.
`include "pps_cfg.svh"

module test_pps_ctrl;
   timeunit 1ns;
   timeprecision 1ps;

   logic        mclk, rst_n, alternate_por_n, flash_addr_line_one;
   logic        link_valid, wake_pkt, bus_idle, master_req, intr_req;
   logic        isolate_n, bus_rst_n, host_stop, cfg_rd, cfg_wr, cfg_ack;
   logic [7:0]  cfg_addr;
   logic [15:0] cfg_wdata, cfg_rdata;
   logic        master_gnt, intr_out, bus_oe_n, clkrun_n_out, clkrun_oe_n;
   logic        pme_n_out, pme_oe_n, link_keep, link_deep_pd, standby;
   logic        dev_init, seen;
   int          num_errors, tests_run;
   // open-drain wires; the event line has a pull-up
   wire clkrun_wire = (!clkrun_oe_n && !clkrun_n_out) ? 1'b0 : host_stop;
   wire pme_wire    = (!pme_oe_n && !pme_n_out) ? 1'b0 : 1'b1;

   pps_ctrl dut (.mclk, .rst_n, .alternate_por_n, .isolate_n, .bus_rst_n,
      .flash_addr_line_one, .link_valid, .wake_pkt,
      .clkrun_n_in(clkrun_wire), .cfg_rd, .cfg_wr, .cfg_addr, .cfg_wdata,
      .cfg_rdata, .cfg_ack, .bus_idle, .master_req, .intr_req, .master_gnt,
      .intr_out, .bus_oe_n, .clkrun_n_out, .clkrun_oe_n, .pme_n_out,
      .pme_oe_n, .link_keep, .link_deep_pd, .standby, .dev_init);
   pps_host host (.mclk, .cfg_rd, .cfg_wr, .cfg_addr, .cfg_wdata, .cfg_rdata,
      .cfg_ack, .isolate_n, .bus_rst_n, .host_stop);

   // 100 MHz, well above the bus clock floor
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic chk(input string nm, input logic [15:0] s, e);
      tests_run++;
      if (s !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask : cyc

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic        ack;
      logic [15:0] r;
      host.access(1'b1, a, d, ack, r);
      chk("write ack", {15'h0, ack}, 16'h0001);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [15:0] e, string nm);
      logic        ack;
      logic [15:0] r;
      host.access(1'b0, a, 16'h0000, ack, r);
      chk("read ack", {15'h0, ack}, 16'h0001);
      chk(nm, r, e);
   endtask : rd

   // sel 0 watches init, sel 1 watches the clock-run claim
   task automatic poll(input int sel);
      seen = 1'b0;
      repeat (6) begin
         @(negedge mclk);
         if (sel == 0 ? dev_init === 1'b1 : clkrun_oe_n === 1'b0) seen = 1'b1;
      end
   endtask : poll

   task automatic done(input string nm);
      $display("test %s finished, mismatches so far %0d", nm, num_errors);
   endtask : done

   task automatic t_reset;
      rd(`PPS_OFF_STAT, 16'h0000, "state after reset");
      rd(`PPS_OFF_PM_CONTROL_STATUS, 16'h0000, "no event after reset");
      chk("grant uninit", {15'h0, master_gnt}, 16'h0000);
      rd(`PPS_OFF_PMC, `PPS_PMC_BASE | 16'h8000, "aux cap");
      wr(`PPS_OFF_BAR_IO, 16'h0000);
      rd(`PPS_OFF_STAT, 16'h0001, "state after bar");
      chk("grant active", {14'h0, master_gnt, intr_out}, 16'h0003);
      done("reset");
   endtask : t_reset

   task automatic t_states;
      logic dp;
      for (int d = 0; d < 2; d++) begin
         wr(`PPS_OFF_DRIVER_PM_REGISTER, 16'(d));
         for (int s = 1; s < 4; s++) begin
            wr(`PPS_OFF_PM_CONTROL_STATUS, 16'h0100 | 16'(s));
            rd(`PPS_OFF_STAT, 16'(s + 1), "state field");
            chk("no mastering", {master_gnt, intr_out}, 16'h0000);
            link_valid = 1'b0;
            cyc(4);
            dp = (d == 1) && (s >= 2);
            chk("deep", {link_deep_pd, link_keep}, {dp, !dp});
            link_valid = 1'b1;
            cyc(4);
            chk("link kept", {15'h0, link_keep}, 16'h0001);
         end
      end
      wr(`PPS_OFF_PM_CONTROL_STATUS, 16'h8003);
      wake_pkt = 1'b1;
      cyc(4);
      wake_pkt = 1'b0;
      chk("d3 no event", {link_keep, pme_wire}, 16'h0001);
      done("states");
   endtask : t_states

   task automatic t_wake;
      wr(`PPS_OFF_PM_CONTROL_STATUS, 16'h8101);
      chk("event idle", {15'h0, pme_wire}, 16'h0001);
      wake_pkt = 1'b1;
      cyc(2);
      wake_pkt = 1'b0;
      cyc(3);
      chk("event on packet", {15'h0, pme_wire}, 16'h0000);
      rd(`PPS_OFF_PM_CONTROL_STATUS, 16'h8101, "event status");
      wr(`PPS_OFF_PM_CONTROL_STATUS, 16'h8001);
      link_valid = 1'b0;
      cyc(5);
      rd(`PPS_OFF_PM_CONTROL_STATUS, 16'h8001, "link event");
      chk("event gated", {15'h0, pme_wire}, 16'h0001);
      link_valid = 1'b1;
      cyc(5);
      wr(`PPS_OFF_PM_CONTROL_STATUS, 16'h8000);
      done("wake");
   endtask : t_wake

   task automatic t_standby;
      host.pins(1'b1, 1'b1, 1'b1);
      poll(1);
      chk("clock claimed", {15'h0, seen}, 16'h0001);
      bus_idle = 1'b1;
      cyc(45);
      chk("no standby yet", {15'h0, standby}, 16'h0000);
      cyc(8);
      chk("standby", {15'h0, standby}, 16'h0001);
      rd(`PPS_OFF_STAT, 16'h0001, "standby hidden");
      poll(1);
      chk("clock may stop", {15'h0, seen}, 16'h0000);
      bus_idle = 1'b0;
      cyc(2);
      chk("standby left", {15'h0, standby}, 16'h0000);
      host.pins(1'b1, 1'b1, 1'b0);
      done("standby");
   endtask : t_standby

   task automatic t_isolate;
      logic        ack;
      logic [15:0] r;
      wr(`PPS_OFF_PM_CONTROL_STATUS, 16'h0100);
      link_valid = 1'b0;
      cyc(5);
      host.pins(1'b0, 1'b1, 1'b0);
      cyc(4);
      chk("isolated pins", {bus_oe_n, pme_wire}, 16'h0002);
      host.access(1'b0, `PPS_OFF_STAT, 16'h0000, ack, r);
      chk("isolated access", {15'h0, ack}, 16'h0000);
      host.pins(1'b0, 1'b0, 1'b0);
      poll(0);
      chk("bus reset ignored", {15'h0, seen}, 16'h0000);
      host.pins(1'b0, 1'b1, 1'b0);
      host.pins(1'b1, 1'b1, 1'b0);
      poll(0);
      chk("release init", {15'h0, seen}, 16'h0001);
      rd(`PPS_OFF_STAT, 16'h0000, "state after init");
      rd(`PPS_OFF_PM_CONTROL_STATUS, 16'h8100, "pm kept");
      host.pins(1'b1, 1'b0, 1'b0);
      poll(0);
      chk("d0 reset init", {15'h0, seen}, 16'h0001);
      host.pins(1'b1, 1'b1, 1'b0);
      cyc(4);
      wr(`PPS_OFF_BAR_CSR, 16'h0000);
      rd(`PPS_OFF_STAT, 16'h0001, "csr bar");
      wr(`PPS_OFF_PM_CONTROL_STATUS, 16'h8103);
      host.pins(1'b1, 1'b0, 1'b0);
      poll(0);
      chk("d3 reset held", {15'h0, seen}, 16'h0000);
      host.pins(1'b1, 1'b1, 1'b0);
      poll(0);
      chk("d3 trailing init", {15'h0, seen}, 16'h0001);
      rd(`PPS_OFF_STAT, 16'h0000, "state after d3");
      done("isolate");
   endtask : t_isolate

   task automatic t_alt;
      flash_addr_line_one = 1'b0;
      alternate_por_n = 1'b0;
      poll(0);
      chk("alt init", {15'h0, seen}, 16'h0001);
      alternate_por_n = 1'b1;
      cyc(4);
      rd(`PPS_OFF_PM_CONTROL_STATUS, 16'h0000, "pm cleared");
      rd(`PPS_OFF_PMC, `PPS_PMC_BASE, "strap sampled");
      cyc(20);
      flash_addr_line_one = 1'b1;
      cyc(4);
      rd(`PPS_OFF_PMC, `PPS_PMC_BASE, "strap held");
      wr(`PPS_OFF_BAR_MEM, 16'h0000);
      rd(`PPS_OFF_STAT, 16'h0001, "mem bar");
      done("alternate");
   endtask : t_alt

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : stop_test

   // whole run is near 310 cycles; allow a wide margin
   initial begin
      #50us;
      num_errors++;
      $display("MISMATCH watchdog expected end seen hang");
      stop_test();
   end

   initial begin
      num_errors = 0;
      tests_run = 0;
      rst_n = 1'b0;
      alternate_por_n = 1'b1;
      flash_addr_line_one = 1'b1;
      link_valid = 1'b1;
      wake_pkt = 1'b0;
      bus_idle = 1'b0;
      master_req = 1'b1;
      intr_req = 1'b1;
      cyc(10);
      rst_n = 1'b1;
      cyc(3);
      t_reset();
      t_states();
      t_wake();
      t_standby();
      t_isolate();
      t_alt();
      stop_test();
   end
endmodule : test_pps_ctrl
